// file: src/gpp_pkg.sv
// Constants for the 32-pin general purpose port block
package gpp_pkg;
   localparam int unsigned NPINS = 32;
   localparam int unsigned AW = 16;
   // Register byte offsets
   localparam logic [15:0] OFF_DIRECTION = 16'hf100;
   localparam logic [15:0] OFF_PIN_VALUE = 16'hf104;
   localparam logic [15:0] OFF_IRQ_CAUSE = 16'hf108;
   localparam logic [15:0] OFF_IRQ_MASK = 16'hf10c;
   localparam logic [15:0] OFF_POLARITY = 16'hf110;
   localparam logic [15:0] OFF_CONTROL = 16'hf114;
   localparam logic [15:0] OFF_EVT_STATUS = 16'hf118;
   localparam logic [15:0] OFF_EVT_CLEAR = 16'hf11c;
   localparam logic [15:0] OFF_EVT_ENABLE = 16'hf120;
   localparam logic [15:0] OFF_PIN_ROUTE = 16'hf124;
   // Field positions
   localparam int unsigned CTL_LEVEL_IRQ_BIT = 0;
   localparam int unsigned EVT_CAUSE_BIT = 0;
   localparam int unsigned EVT_RO_WRITE_BIT = 1;
   localparam int unsigned EVT_W = 2;
   // Reset values
   localparam logic [31:0] RST_DIRECTION = 32'h0000_0000;
   localparam logic [31:0] RST_POLARITY = 32'h0000_0000;
   localparam logic [31:0] RST_PIN_VALUE = 32'h0000_0000;
   localparam logic [31:0] RST_IRQ_CAUSE = 32'h0000_0000;
   localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;
   localparam logic RST_LEVEL_IRQ = 1'b0;
   localparam logic [1:0] RST_EVT = 2'h0;
   localparam logic [31:0] RST_PIN_ROUTE = 32'h0000_0000;
   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'b0;
endpackage

// file: src/gpp_port.sv
// General purpose port: pins, polarity, cause/mask and AHB-Lite slave
`timescale 1ns/100ps

module gpp_port (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Pins
   input wire logic [31:0] pin_in,
   output logic [31:0] pin_out,
   output logic [31:0] pin_oe,
   // Shared pin routing, one means general port
   output logic [31:0] route_general_port,
   // Interrupts
   output logic port_irq,
   output logic event_irq
);

   typedef struct packed {
      logic [31:0] sync1;
      logic [31:0] sync2;
      logic [31:0] in_lvl;
      logic [31:0] direction;
      logic [31:0] polarity;
      logic [31:0] pin_value;
      logic [31:0] cause;
      logic [31:0] mask;
      logic level_irq_select;
      logic [31:0] alt_route;
      logic [1:0] evt_status;
      logic [1:0] evt_enable;
      logic wr_pend;
      logic [15:0] wr_addr;
      logic [31:0] rdata;
      logic [31:0] drive;
      logic [31:0] oe;
   } gpp_state_t;

   gpp_state_t state;
   gpp_state_t next_state;

   logic addr_phase;
   logic [15:0] a_off;
   logic [31:0] rd_mux;
   logic [31:0] asserted_in;
   logic [31:0] rise;
   logic [31:0] wr_data;
   logic wr_dir;
   logic wr_pol;
   logic wr_val;
   logic wr_cause;
   logic wr_mask;
   logic wr_ctl;
   logic wr_eclr;
   logic wr_een;
   logic wr_route;

   assign addr_phase = hsel && hready && htrans[1];
   assign a_off = haddr[15:0];
   assign wr_data = hwdata;

   ////////////////////////////////////////////////////////////////////
   // Read mux, taken in the address phase
   always_comb begin
      case (a_off)
         gpp_pkg::OFF_DIRECTION: rd_mux = state.direction;
         gpp_pkg::OFF_PIN_VALUE: rd_mux = state.pin_value;
         gpp_pkg::OFF_IRQ_CAUSE: rd_mux = state.cause;
         gpp_pkg::OFF_IRQ_MASK: rd_mux = state.mask;
         gpp_pkg::OFF_POLARITY: rd_mux = state.polarity;
         gpp_pkg::OFF_CONTROL: rd_mux = {31'h0, state.level_irq_select};
         gpp_pkg::OFF_EVT_STATUS: rd_mux = {30'h0, state.evt_status};
         gpp_pkg::OFF_EVT_ENABLE: rd_mux = {30'h0, state.evt_enable};
         gpp_pkg::OFF_PIN_ROUTE: rd_mux = state.alt_route;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Write strobes, data phase
   always_comb begin
      wr_dir = state.wr_pend && (state.wr_addr == gpp_pkg::OFF_DIRECTION);
      wr_pol = state.wr_pend && (state.wr_addr == gpp_pkg::OFF_POLARITY);
      wr_val = state.wr_pend && (state.wr_addr == gpp_pkg::OFF_PIN_VALUE);
      wr_cause = state.wr_pend && (state.wr_addr == gpp_pkg::OFF_IRQ_CAUSE);
      wr_mask = state.wr_pend && (state.wr_addr == gpp_pkg::OFF_IRQ_MASK);
      wr_ctl = state.wr_pend && (state.wr_addr == gpp_pkg::OFF_CONTROL);
      wr_eclr = state.wr_pend && (state.wr_addr == gpp_pkg::OFF_EVT_CLEAR);
      wr_een = state.wr_pend && (state.wr_addr == gpp_pkg::OFF_EVT_ENABLE);
      wr_route = state.wr_pend && (state.wr_addr == gpp_pkg::OFF_PIN_ROUTE);
   end

   ////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_state = state;
      next_state.sync1 = pin_in;
      next_state.sync2 = state.sync1;
      asserted_in = state.sync2 ^ state.polarity;
      next_state.in_lvl = asserted_in;
      rise = asserted_in & ~state.in_lvl & ~state.direction;

      // Bus address phase capture
      next_state.wr_pend = addr_phase && hwrite;
      if (addr_phase) begin
         next_state.wr_addr = a_off;
      end
      if (addr_phase && !hwrite) begin
         next_state.rdata = rd_mux;
      end

      if (wr_dir) begin
         next_state.direction = wr_data;
      end
      if (wr_pol) begin
         next_state.polarity = wr_data;
      end
      if (wr_mask) begin
         next_state.mask = wr_data;
      end
      if (wr_ctl) begin
         next_state.level_irq_select = wr_data[gpp_pkg::CTL_LEVEL_IRQ_BIT];
      end
      if (wr_een) begin
         next_state.evt_enable = wr_data[gpp_pkg::EVT_W-1:0];
      end
      if (wr_route) begin
         next_state.alt_route = wr_data;
      end

      // input bits latch pin level with polarity applied, output bits keep writes
      next_state.pin_value = (asserted_in & ~state.direction)
         | (state.pin_value & state.direction);
      if (wr_val) begin
         next_state.pin_value = (asserted_in & ~state.direction)
            | (wr_data & state.direction);
      end

      // write zero clears, set ignores mask, set wins
      next_state.cause = state.cause;
      if (wr_cause) begin
         next_state.cause = state.cause & wr_data;
      end
      next_state.cause = next_state.cause | rise;

      // Block events: new cause, ignored write to input bits
      next_state.evt_status = state.evt_status;
      if (wr_eclr) begin
         next_state.evt_status = state.evt_status
            & ~wr_data[gpp_pkg::EVT_W-1:0];
      end
      if (|rise) begin
         next_state.evt_status[gpp_pkg::EVT_CAUSE_BIT] = 1'b1;
      end
      if (wr_val && |(wr_data & ~state.direction)) begin
         next_state.evt_status[gpp_pkg::EVT_RO_WRITE_BIT] = 1'b1;
      end

      // drive with polarity, continuous drive of outputs
      next_state.drive = next_state.pin_value ^ next_state.polarity;
      next_state.oe = next_state.direction;
   end

   ////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state.sync1 <= 32'h0000_0000;
         state.sync2 <= 32'h0000_0000;
         state.in_lvl <= 32'h0000_0000;
         state.direction <= gpp_pkg::RST_DIRECTION;
         state.polarity <= gpp_pkg::RST_POLARITY;
         state.pin_value <= gpp_pkg::RST_PIN_VALUE;
         state.cause <= gpp_pkg::RST_IRQ_CAUSE;
         state.mask <= gpp_pkg::RST_IRQ_MASK;
         state.level_irq_select <= gpp_pkg::RST_LEVEL_IRQ;
         state.alt_route <= gpp_pkg::RST_PIN_ROUTE;
         state.evt_status <= gpp_pkg::RST_EVT;
         state.evt_enable <= gpp_pkg::RST_EVT;
         state.wr_pend <= 1'b0;
         state.wr_addr <= 16'h0000;
         state.rdata <= 32'h0000_0000;
         state.drive <= 32'h0000_0000;
         state.oe <= 32'h0000_0000;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   assign hrdata = state.rdata;
   assign hreadyout = 1'b1;
   assign hresp = gpp_pkg::HRESP_OKAY;
   assign pin_out = state.drive;
   assign pin_oe = state.oe;
   assign route_general_port = ~state.alt_route;

   // mask gating, edge mode, level mode
   always_comb begin
      if (state.level_irq_select) begin
         port_irq = |(state.pin_value & state.mask);
      end else begin
         port_irq = |(state.cause & state.mask);
      end
   end

   assign event_irq = |(state.evt_status & state.evt_enable);

endmodule

// file: tb/gpp_pin_model.sv
// External devices facing the general purpose port pins
`timescale 1ns/100ps
module gpp_pin_model (
   // From the port
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   // Levels the devices want
   input wire logic [31:0] drive,
   // To the port
   output logic [31:0] pin_in
);
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule

// file: tb/gpp_port_monitor.sv
// Port checker bound to the general purpose port
`timescale 1ns/100ps
module gpp_port_monitor (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input logic hreadyout,
   input logic hresp,
   // Pins and interrupts
   input wire logic [31:0] pin_in,
   input logic [31:0] pin_out,
   input logic [31:0] pin_oe,
   input logic [31:0] route_general_port,
   input logic port_irq,
   input logic event_irq
);
   logic wr;
   assign wr = hsel & hready & htrans[1] & hwrite;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_always_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_reset_idle: assert property ($rose(hresetn) |->
      pin_oe == 32'h0 && pin_out == 32'h0 && !port_irq)
      else $error("pins or irq active after reset");
   a_route_reset: assert property ($rose(hresetn) |->
      route_general_port == 32'hffff_ffff) else $error("route not general");
   a_oe_from_write: assert property ($changed(pin_oe) |-> $past(wr, 2))
      else $error("output enable moved without write");
   a_drive_from_write: assert property ($changed(pin_out & pin_oe) |->
      $past(wr, 2)) else $error("output drive moved without write");
   a_irq_has_cause: assert property ($changed(port_irq) |->
      $past(wr, 2) || $past(wr, 3) || $past(pin_in, 3) != $past(pin_in, 4))
      else $error("port irq moved without cause");
   a_event_has_cause: assert property ($changed(event_irq) |->
      $past(wr, 2) || $past(wr, 3) || $past(pin_in, 3) != $past(pin_in, 4))
      else $error("event irq moved without cause");
   a_route_from_write: assert property ($changed(route_general_port) |->
      $past(wr, 2) || $past(wr, 3)) else $error("route moved without write");
   c_irq_raised: cover property ($rose(port_irq));
   c_event_raised: cover property ($rose(event_irq));
   c_output_on: cover property ($rose(pin_oe[0]));
endmodule
bind gpp_port gpp_port_monitor gpp_port_monitor_i (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe(pin_oe), .port_irq(port_irq),
   .route_general_port(route_general_port), .event_irq(event_irq));

// file: tb/tb_gpp_port.sv
// Testbench for the general purpose port
`timescale 1ns/100ps
module tb_gpp_port;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, port_irq, event_irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, pin_in, pin_out, pin_oe, drive, rt;
   logic [31:0] v;
   logic [15:0] a;
   int n_mismatch = 0;
   int samples_checked = 0;
   gpp_port gpp_port_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .route_general_port(rt),
      .port_irq(port_irq), .event_irq(event_irq));
   gpp_pin_model gpp_pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe),
      .drive(drive), .pin_in(pin_in));
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task report_and_stop;
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task hw;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         n_mismatch++;
         report_and_stop;
      end
   endtask
   task xfer(input logic [15:0] ad, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {16'h0, ad};
      hwrite <= w;
      htrans <= gpp_pkg::HTRANS_NONSEQ;
      hw();
      htrans <= 2'h0;
      hwdata <= d;
      hw();
      v = hrdata;
   endtask
   task rd(input logic [15:0] ad, input logic [31:0] e);
      xfer(ad, 1'b0, 32'h0);
      chk(v, e);
   endtask
   task pin(input int i, input logic l);
      drive[i] <= l;
      repeat (5) @(posedge hclk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, drive} = '0;
      hsize = 3'h2;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (a = 16'hf100; a <= 16'hf110; a += 16'h4) rd(a, 32'h0);
      chk(rt, 32'hffff_ffff);
      rd(16'hf1fc, 32'h0);
      xfer(gpp_pkg::OFF_DIRECTION, 1'b1, 32'h0000_00ff);
      xfer(gpp_pkg::OFF_POLARITY, 1'b1, 32'h0000_000f);
      xfer(gpp_pkg::OFF_PIN_VALUE, 1'b1, 32'hffff_ffff);
      repeat (3) @(posedge hclk);
      chk(pin_oe, 32'h0000_00ff);
      chk(pin_out & pin_oe, 32'h0000_00f0);
      rd(gpp_pkg::OFF_PIN_VALUE, 32'h0000_00ff);
      xfer(gpp_pkg::OFF_IRQ_MASK, 1'b1, 32'h0000_0200);
      pin(9, 1'b1);
      pin(10, 1'b1);
      rd(gpp_pkg::OFF_IRQ_CAUSE, 32'h0000_0600);
      chk({31'h0, port_irq}, 32'h1);
      xfer(gpp_pkg::OFF_IRQ_CAUSE, 1'b1, 32'hffff_ffff);
      rd(gpp_pkg::OFF_IRQ_CAUSE, 32'h0000_0600);
      xfer(gpp_pkg::OFF_IRQ_CAUSE, 1'b1, 32'hffff_fdff);
      repeat (2) @(posedge hclk);
      chk({31'h0, port_irq}, 32'h0);
      pin(11, 1'b1);
      xfer(gpp_pkg::OFF_POLARITY, 1'b1, 32'h0000_080f);
      repeat (4) @(posedge hclk);
      rd(gpp_pkg::OFF_PIN_VALUE, 32'h0000_06ff);
      xfer(gpp_pkg::OFF_IRQ_CAUSE, 1'b1, 32'hffff_f7ff);
      rd(gpp_pkg::OFF_IRQ_CAUSE, 32'h0000_0400);
      pin(11, 1'b0);
      rd(gpp_pkg::OFF_IRQ_CAUSE, 32'h0000_0c00);
      xfer(gpp_pkg::OFF_CONTROL, 1'b1, 32'h1);
      xfer(gpp_pkg::OFF_IRQ_MASK, 1'b1, 32'h0000_0400);
      pin(10, 1'b0);
      chk({31'h0, port_irq}, 32'h0);
      pin(10, 1'b1);
      chk({31'h0, port_irq}, 32'h1);
      rd(gpp_pkg::OFF_EVT_STATUS, 32'h3);
      chk({31'h0, event_irq}, 32'h0);
      xfer(gpp_pkg::OFF_EVT_ENABLE, 1'b1, 32'h1);
      repeat (2) @(posedge hclk);
      chk({31'h0, event_irq}, 32'h1);
      xfer(gpp_pkg::OFF_EVT_CLEAR, 1'b1, 32'h3);
      repeat (2) @(posedge hclk);
      chk({31'h0, event_irq}, 32'h0);
      xfer(gpp_pkg::OFF_PIN_ROUTE, 1'b1, 32'h1);
      repeat (2) @(posedge hclk);
      chk(rt, 32'hffff_fffe);
      report_and_stop;
   end
endmodule
